// *** pkg/ids_consts.vh ***
`ifndef IDS_CONSTS_VH
`define IDS_CONSTS_VH
// ****************************************
// Addressing modes of a byte access
// ****************************************
`define IDS_MODE_DIRECT   2'h0
`define IDS_MODE_INDIRECT 2'h1
`define IDS_MODE_REGISTER 2'h2
// ****************************************
// Register space offsets
// ****************************************
`define IDS_A_SP    8'h81
`define IDS_A_DPL   8'h82
`define IDS_A_DPH   8'h83
`define IDS_A_TL0   8'h8A
`define IDS_A_TL1   8'h8B
`define IDS_A_TH0   8'h8C
`define IDS_A_TH1   8'h8D
`define IDS_A_P1    8'h90
`define IDS_A_SBUF2 8'h95
`define IDS_A_SBUF0 8'h99
`define IDS_A_SBUF1 8'h9B
`define IDS_A_P3M   8'h9C
`define IDS_A_P4M   8'h9D
`define IDS_A_P5M   8'h9E
`define IDS_A_P2    8'hA0
`define IDS_A_MISC_CONTROL  8'hA2
`define IDS_A_P3    8'hB0
`define IDS_A_P4    8'hC0
`define IDS_A_P5    8'hC4
`define IDS_A_TL2   8'hCC
`define IDS_A_TH2   8'hCD
`define IDS_A_PSW   8'hD0
`define IDS_A_ACC   8'hE0
`define IDS_A_B     8'hF0
`define IDS_A_LOADER_SETTINGS  8'hF1
`define IDS_A_WDT   8'hFF
// ****************************************
// Reset values, masks and field positions
// ****************************************
`define IDS_SP_RST      8'h07
`define IDS_PORT_RST    8'hFF
`define IDS_ZERO8       8'h00
`define IDS_ZERO16      16'h0000
`define IDS_ZERO3       3'h0
`define IDS_ZERO24      24'h000000
`define IDS_ZERO32      32'h00000000
`define IDS_ONES32      32'hFFFFFFFF
`define IDS_MISC_CONTROL_MASK   8'h39
`define IDS_LOADER_SETTINGS_MASK   8'h07
`define IDS_BIT_BASE    4'h2
`define IDS_PSW_RS_HI   4
`define IDS_PSW_RS_LO   3
`define IDS_MISC_CONTROL_DPS    0
`endif

// *** rtl/ids_space.v ***
// Notes on behaviour
// RULE1: 384 bytes: lower, upper, register blocks.
// RULE2: High direct hits registers, indirect hits RAM.
// RULE3: Low 32 bytes: four banks, status selects.
// RULE4: Bytes 20h-2Fh bit addressed 00h-7Fh.
// RULE5: Lower 128 same for direct and indirect.
// RULE6: Only x0h/x8h registers are bit addressable.
// RULE7: Unimplemented reads arbitrary; software never writes.
// RULE8: Status word layout carry down to parity.
// RULE9: Parity tracks accumulator ones count continuously.
// RULE10: Stack pointer resets 07h, fully writable.
// RULE11: Accumulator E0h, multiply scratch F0h.
// RULE12: Misc control: reset, flag, wake, zero, select.
// RULE13: Pointer bytes map to selected pointer.
// RULE14: Port bit drives pin; set before input.
// RULE15: Ports 3-5 pseudo, drive-mode bit push-pull.
// RULE16: External move indirect uses port-2 high byte.
// RULE17: Serial buffer: write transmits, read receives.
// RULE18: Loader: reload, reload on timeout, doubler.
// RULE19: Timer pairs and watchdog count registers.
// RULE20: Status, control, loader clear; reserved zero.
`timescale 1ns/10ps
`default_nettype none
`include "ids_consts.vh"

module ids_space (
  input  wire        sys_clk,
  input  wire        rst,
  input  wire        acc_rd,
  input  wire        acc_wr,
  input  wire [1:0]  acc_mode,
  input  wire [7:0]  acc_addr,
  input  wire [7:0]  acc_wdata,
  input  wire        bit_rd,
  input  wire        bit_wr,
  input  wire [7:0]  bit_addr,
  input  wire        bit_wval,
  input  wire        data_pointer_wr,
  input  wire [15:0] data_pointer_wdata,
  input  wire [23:0] serial_rx_data,
  input  wire [31:0] port_pin_in,
  output reg  [7:0]  rd_data_r,
  output reg         bit_rd_data_r,
  output reg  [7:0]  stack_pointer_r,
  output reg  [15:0] data_pointer_zero_r,
  output reg  [15:0] data_pointer_one_r,
  output reg  [7:0]  upper_address_port_r,
  output reg  [7:0]  misc_control_r,
  output reg  [7:0]  loader_settings_r,
  output reg  [23:0] serial_tx_data_r,
  output reg  [2:0]  serial_tx_start_r,
  output reg  [31:0] port_pin_out_r,
  output reg  [31:0] port_pin_oe_r
);

  // ****************************************
  // Storage
  // ****************************************
  // RULE1: three blocks
  // Lower and upper blocks share one array; registers live apart below
  reg [7:0]  iram [0:255];
  reg [7:0]  psw_r;
  reg [7:0]  main_operand_reg_r;
  reg [7:0]  multiply_scratch_r;
  reg [7:0]  port1_r;
  reg [7:0]  port3_r;
  reg [7:0]  port4_r;
  reg [7:0]  port5_r;
  reg [7:0]  port3_drive_mode_r;
  reg [7:0]  port4_drive_mode_r;
  reg [7:0]  port5_drive_mode_r;
  reg [7:0]  tl0_r;
  reg [7:0]  th0_r;
  reg [7:0]  tl1_r;
  reg [7:0]  th1_r;
  reg [7:0]  tl2_r;
  reg [7:0]  th2_r;
  reg [7:0]  watchdog_count_r;
  reg [31:0] latch_d_r;
  reg [31:0] pin_meta_r;
  reg [31:0] pin_sync_r;

  // ****************************************
  // Derived values
  // ****************************************
  wire        parity_now;
  wire [1:0]  bank_sel;
  wire        ptr_sel;
  wire [31:0] latch_all;
  wire [31:0] push_pull;
  reg         byte_sfr;
  reg  [7:0]  byte_addr;
  reg         bit_sfr;
  reg  [7:0]  bit_byte;
  reg  [7:0]  bit_src;
  reg  [7:0]  bit_mask;
  reg         wr_en;
  reg         wr_sfr;
  reg  [7:0]  wr_addr;
  reg  [7:0]  wr_data;
  reg  [7:0]  sfr_a;
  reg  [7:0]  sfr_q;

  // RULE9: live parity
  assign parity_now = ^main_operand_reg_r;
  // RULE3: bank from status word
  assign bank_sel   = {psw_r[`IDS_PSW_RS_HI], psw_r[`IDS_PSW_RS_LO]};
  assign ptr_sel    = misc_control_r[`IDS_MISC_CONTROL_DPS];
  assign latch_all  = {port5_r, port4_r, port3_r, port1_r};
  // Port 1 has no drive-mode register and stays pseudo-bidirectional
  assign push_pull  = {port5_drive_mode_r, port4_drive_mode_r, port3_drive_mode_r, `IDS_ZERO8};

  // ****************************************
  // Register space read decode
  // ****************************************
  // Port 1, 3, 4 and 5 reads return the synchronised pin, as software expects when using inputs; port 2 reads its latch
  // A block, not a function: @* does not see the registers that a function reads
  // One decode serves both paths; a bit access takes it from a byte read in one cycle
  always @* begin
    sfr_a = (bit_rd || bit_wr) ? bit_byte : byte_addr;
    if (sfr_a == `IDS_A_SP)
      sfr_q = stack_pointer_r;
    // RULE13: selected pointer
    else if (sfr_a == `IDS_A_DPL)
      sfr_q = ptr_sel ? data_pointer_one_r[7:0] : data_pointer_zero_r[7:0];
    else if (sfr_a == `IDS_A_DPH)
      sfr_q = ptr_sel ? data_pointer_one_r[15:8] : data_pointer_zero_r[15:8];
    // RULE19: timer count pairs
    else if (sfr_a == `IDS_A_TL0)
      sfr_q = tl0_r;
    else if (sfr_a == `IDS_A_TH0)
      sfr_q = th0_r;
    else if (sfr_a == `IDS_A_TL1)
      sfr_q = tl1_r;
    else if (sfr_a == `IDS_A_TH1)
      sfr_q = th1_r;
    else if (sfr_a == `IDS_A_TL2)
      sfr_q = tl2_r;
    else if (sfr_a == `IDS_A_TH2)
      sfr_q = th2_r;
    else if (sfr_a == `IDS_A_WDT)
      sfr_q = watchdog_count_r;
    else if (sfr_a == `IDS_A_P1)
      sfr_q = pin_sync_r[7:0];
    else if (sfr_a == `IDS_A_P3)
      sfr_q = pin_sync_r[15:8];
    else if (sfr_a == `IDS_A_P4)
      sfr_q = pin_sync_r[23:16];
    else if (sfr_a == `IDS_A_P5)
      sfr_q = pin_sync_r[31:24];
    else if (sfr_a == `IDS_A_P2)
      sfr_q = upper_address_port_r;
    else if (sfr_a == `IDS_A_P3M)
      sfr_q = port3_drive_mode_r;
    else if (sfr_a == `IDS_A_P4M)
      sfr_q = port4_drive_mode_r;
    else if (sfr_a == `IDS_A_P5M)
      sfr_q = port5_drive_mode_r;
    // RULE17: reads return receive side
    else if (sfr_a == `IDS_A_SBUF0)
      sfr_q = serial_rx_data[7:0];
    else if (sfr_a == `IDS_A_SBUF1)
      sfr_q = serial_rx_data[15:8];
    else if (sfr_a == `IDS_A_SBUF2)
      sfr_q = serial_rx_data[23:16];
    // RULE12: bit 2 reads zero
    else if (sfr_a == `IDS_A_MISC_CONTROL)
      sfr_q = misc_control_r & `IDS_MISC_CONTROL_MASK;
    else if (sfr_a == `IDS_A_LOADER_SETTINGS)
      sfr_q = loader_settings_r & `IDS_LOADER_SETTINGS_MASK;
    // RULE8: status layout with parity
    else if (sfr_a == `IDS_A_PSW)
      sfr_q = {psw_r[7:1], parity_now};
    // RULE11: accumulator and scratch
    else if (sfr_a == `IDS_A_ACC)
      sfr_q = main_operand_reg_r;
    else if (sfr_a == `IDS_A_B)
      sfr_q = multiply_scratch_r;
    // RULE7: unimplemented reads zero
    else
      sfr_q = `IDS_ZERO8;
  end

  // ****************************************
  // Address resolution for byte and bit paths
  // ****************************************
  // Byte access mapping by mode
  always @* begin
    if (acc_mode == `IDS_MODE_REGISTER) begin
      // RULE3: banked working register
      byte_sfr  = 1'b0;
      byte_addr = {3'b000, bank_sel, acc_addr[2:0]};
    end else begin
      // RULE2: high direct goes to registers
      // RULE5: low half identical in both modes
      byte_sfr  = (acc_mode == `IDS_MODE_DIRECT) && acc_addr[7];
      byte_addr = acc_addr;
    end
  end

  // Bit access mapping
  always @* begin
    bit_sfr = bit_addr[7];
    // RULE6: register bits only at x0h/x8h
    // RULE4: RAM bits in bytes 20h-2Fh
    if (bit_sfr)
      bit_byte = {bit_addr[7:3], 3'b000};
    else
      bit_byte = {`IDS_BIT_BASE, bit_addr[6:3]};
    bit_src  = bit_sfr ? sfr_q : iram[bit_byte];
    bit_mask = 8'h01 << bit_addr[2:0];
  end

  // Write merge: byte write wins over a bit write in the same cycle
  always @* begin
    wr_en   = acc_wr | bit_wr;
    wr_sfr  = acc_wr ? byte_sfr : bit_sfr;
    wr_addr = acc_wr ? byte_addr : bit_byte;
    if (acc_wr)
      wr_data = acc_wdata;
    else if (bit_wval)
      wr_data = bit_src | bit_mask;
    else
      wr_data = bit_src & ~bit_mask;
  end

  // ****************************************
  // Internal RAM
  // ****************************************
  // No reset on the array; contents are undefined until written
  always @(posedge sys_clk) begin
    if (wr_en && !wr_sfr)
      iram[wr_addr] <= wr_data;
  end

  // ****************************************
  // Read data
  // ****************************************
  always @(posedge sys_clk) begin
    if (rst) begin
      rd_data_r     <= `IDS_ZERO8;
      bit_rd_data_r <= 1'b0;
    end else begin
      if (acc_rd)
        rd_data_r <= byte_sfr ? sfr_q : iram[byte_addr];
      if (bit_rd)
        bit_rd_data_r <= bit_src[bit_addr[2:0]];
    end
  end

  // ****************************************
  // Register space writes
  // ****************************************
  always @(posedge sys_clk) begin
    if (rst) begin
      // RULE10: stack pointer reset
      stack_pointer_r      <= `IDS_SP_RST;
      // RULE20: cleared control registers
      psw_r                <= `IDS_ZERO8;
      misc_control_r       <= `IDS_ZERO8;
      loader_settings_r    <= `IDS_ZERO8;
      main_operand_reg_r   <= `IDS_ZERO8;
      multiply_scratch_r   <= `IDS_ZERO8;
      data_pointer_zero_r  <= `IDS_ZERO16;
      data_pointer_one_r   <= `IDS_ZERO16;
      upper_address_port_r <= `IDS_PORT_RST;
      port1_r              <= `IDS_PORT_RST;
      port3_r              <= `IDS_PORT_RST;
      port4_r              <= `IDS_PORT_RST;
      port5_r              <= `IDS_PORT_RST;
      // RULE15: pseudo-bidirectional default
      port3_drive_mode_r   <= `IDS_ZERO8;
      port4_drive_mode_r   <= `IDS_ZERO8;
      port5_drive_mode_r   <= `IDS_ZERO8;
      tl0_r                <= `IDS_ZERO8;
      th0_r                <= `IDS_ZERO8;
      tl1_r                <= `IDS_ZERO8;
      th1_r                <= `IDS_ZERO8;
      tl2_r                <= `IDS_ZERO8;
      th2_r                <= `IDS_ZERO8;
      watchdog_count_r     <= `IDS_ZERO8;
      serial_tx_data_r     <= `IDS_ZERO24;
      serial_tx_start_r    <= `IDS_ZERO3;
    end else begin
      serial_tx_start_r <= `IDS_ZERO3;
      // RULE13: whole pointer update to selected one
      if (data_pointer_wr && !ptr_sel)
        data_pointer_zero_r <= data_pointer_wdata;
      if (data_pointer_wr && ptr_sel)
        data_pointer_one_r <= data_pointer_wdata;
      // RULE7: unmatched addresses ignore writes
      if (wr_en && wr_sfr) begin
        // RULE10: any value accepted
        if (wr_addr == `IDS_A_SP)
          stack_pointer_r <= wr_data;
        // RULE13: byte halves of selected pointer
        else if (wr_addr == `IDS_A_DPL && !ptr_sel)
          data_pointer_zero_r[7:0] <= wr_data;
        else if (wr_addr == `IDS_A_DPL)
          data_pointer_one_r[7:0] <= wr_data;
        else if (wr_addr == `IDS_A_DPH && !ptr_sel)
          data_pointer_zero_r[15:8] <= wr_data;
        else if (wr_addr == `IDS_A_DPH)
          data_pointer_one_r[15:8] <= wr_data;
        // RULE19: count register storage
        else if (wr_addr == `IDS_A_TL0)
          tl0_r <= wr_data;
        else if (wr_addr == `IDS_A_TH0)
          th0_r <= wr_data;
        else if (wr_addr == `IDS_A_TL1)
          tl1_r <= wr_data;
        else if (wr_addr == `IDS_A_TH1)
          th1_r <= wr_data;
        else if (wr_addr == `IDS_A_TL2)
          tl2_r <= wr_data;
        else if (wr_addr == `IDS_A_TH2)
          th2_r <= wr_data;
        else if (wr_addr == `IDS_A_WDT)
          watchdog_count_r <= wr_data;
        // RULE14: port latches
        else if (wr_addr == `IDS_A_P1)
          port1_r <= wr_data;
        else if (wr_addr == `IDS_A_P3)
          port3_r <= wr_data;
        else if (wr_addr == `IDS_A_P4)
          port4_r <= wr_data;
        else if (wr_addr == `IDS_A_P5)
          port5_r <= wr_data;
        // RULE16: high byte for external move
        else if (wr_addr == `IDS_A_P2)
          upper_address_port_r <= wr_data;
        // RULE15: drive-mode registers
        else if (wr_addr == `IDS_A_P3M)
          port3_drive_mode_r <= wr_data;
        else if (wr_addr == `IDS_A_P4M)
          port4_drive_mode_r <= wr_data;
        else if (wr_addr == `IDS_A_P5M)
          port5_drive_mode_r <= wr_data;
        // RULE17: write loads and starts
        else if (wr_addr == `IDS_A_SBUF0) begin
          serial_tx_data_r[7:0] <= wr_data;
          serial_tx_start_r[0]  <= 1'b1;
        end else if (wr_addr == `IDS_A_SBUF1) begin
          serial_tx_data_r[15:8] <= wr_data;
          serial_tx_start_r[1]   <= 1'b1;
        end else if (wr_addr == `IDS_A_SBUF2) begin
          serial_tx_data_r[23:16] <= wr_data;
          serial_tx_start_r[2]    <= 1'b1;
        end
        // RULE12: reserved and fixed bits kept zero
        else if (wr_addr == `IDS_A_MISC_CONTROL)
          misc_control_r <= wr_data & `IDS_MISC_CONTROL_MASK;
        // RULE18: loader bits
        else if (wr_addr == `IDS_A_LOADER_SETTINGS)
          loader_settings_r <= wr_data & `IDS_LOADER_SETTINGS_MASK;
        // RULE9: parity is not writable
        else if (wr_addr == `IDS_A_PSW)
          psw_r <= {wr_data[7:1], 1'b0};
        // RULE11: accumulator and scratch
        else if (wr_addr == `IDS_A_ACC)
          main_operand_reg_r <= wr_data;
        else if (wr_addr == `IDS_A_B)
          multiply_scratch_r <= wr_data;
      end
    end
  end

  // ****************************************
  // Port pins
  // ****************************************
  // Two-stage synchroniser on pin inputs
  always @(posedge sys_clk) begin
    if (rst) begin
      pin_meta_r <= `IDS_ZERO32;
      pin_sync_r <= `IDS_ZERO32;
    end else begin
      pin_meta_r <= port_pin_in;
      pin_sync_r <= pin_meta_r;
    end
  end

  // Pseudo mode drives a 0 hard, and a 1 hard for one cycle after a rise
  always @(posedge sys_clk) begin
    if (rst) begin
      latch_d_r      <= `IDS_ONES32;
      port_pin_out_r <= `IDS_ONES32;
      port_pin_oe_r  <= `IDS_ZERO32;
    end else begin
      latch_d_r      <= latch_all;
      // RULE14: pin follows latch
      port_pin_out_r <= latch_all;
      // RULE15: push-pull always drives
      port_pin_oe_r  <= ~latch_all | push_pull | (latch_all & ~latch_d_r);
    end
  end

endmodule // ids_space
`default_nettype wire

// *** verif/ids_space_monitor.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "ids_consts.vh"
// ****************************************
// Port-level checker
// ****************************************
module ids_space_monitor (
  input wire logic        sys_clk,
  input wire logic        rst,
  input wire logic        acc_wr,
  input wire logic [1:0]  acc_mode,
  input wire logic [7:0]  acc_addr,
  input wire logic [7:0]  acc_wdata,
  input wire logic        data_pointer_wr,
  input wire logic [15:0] data_pointer_wdata,
  input wire logic [7:0]  stack_pointer_r,
  input wire logic [15:0] data_pointer_zero_r,
  input wire logic [15:0] data_pointer_one_r,
  input wire logic [7:0]  upper_address_port_r,
  input wire logic [7:0]  misc_control_r,
  input wire logic [7:0]  loader_settings_r,
  input wire logic [23:0] serial_tx_data_r,
  input wire logic [2:0]  serial_tx_start_r,
  input wire logic [31:0] port_pin_out_r,
  input wire logic [31:0] port_pin_oe_r
);
  default clocking dc @(posedge sys_clk); endclocking
  default disable iff (rst);
  // Direct and indirect byte writes
  wire logic dw = acc_wr && (acc_mode == `IDS_MODE_DIRECT);
  wire logic iw = acc_wr && (acc_mode == `IDS_MODE_INDIRECT);
  a_reset_state:
  assert property (disable iff (1'b0) rst |=> stack_pointer_r == `IDS_SP_RST
    && misc_control_r == 8'h00 && loader_settings_r == 8'h00
    && port_pin_oe_r == 32'h00000000 && port_pin_out_r == 32'hFFFFFFFF)
    else $error("reset state wrong");
  a_sp_load:
  assert property (dw && acc_addr == `IDS_A_SP |=> stack_pointer_r == $past(acc_wdata))
    else $error("stack pointer not loaded");
  a_upper_ram:
  assert property (iw && acc_addr[7] |=> $stable(stack_pointer_r)
    && $stable(upper_address_port_r) && $stable(misc_control_r))
    else $error("indirect high write reached registers");
  a_misc_write:
  assert property (dw && acc_addr == `IDS_A_MISC_CONTROL
    |=> misc_control_r == ($past(acc_wdata) & `IDS_MISC_CONTROL_MASK))
    else $error("misc control value wrong");
  a_loader_write:
  assert property (dw && acc_addr == `IDS_A_LOADER_SETTINGS
    |=> loader_settings_r == ($past(acc_wdata) & `IDS_LOADER_SETTINGS_MASK))
    else $error("loader settings value wrong");
  a_port2_write:
  assert property (dw && acc_addr == `IDS_A_P2 |=> upper_address_port_r == $past(acc_wdata))
    else $error("port 2 not loaded");
  a_ptr_select:
  assert property (data_pointer_wr && !acc_wr |=> misc_control_r[`IDS_MISC_CONTROL_DPS]
    ? (data_pointer_one_r == $past(data_pointer_wdata) && $stable(data_pointer_zero_r))
    : (data_pointer_zero_r == $past(data_pointer_wdata) && $stable(data_pointer_one_r)))
    else $error("wrong pointer loaded");
  a_tx_pulse:
  assert property (dw && acc_addr == `IDS_A_SBUF1 |=> serial_tx_start_r[1]
    && serial_tx_data_r[15:8] == $past(acc_wdata)
    ##1 serial_tx_start_r[1] == $past(dw && acc_addr == `IDS_A_SBUF1))
    else $error("transmit start wrong");
  c_tx: cover property (dw && acc_addr == `IDS_A_SBUF1);
  c_ptr: cover property (data_pointer_wr);
  c_upper: cover property (iw && acc_addr[7]);
endmodule // ids_space_monitor
bind ids_space ids_space_monitor mon (.sys_clk, .rst, .acc_wr, .acc_mode, .acc_addr,
  .acc_wdata, .data_pointer_wr, .data_pointer_wdata, .stack_pointer_r, .data_pointer_zero_r,
  .data_pointer_one_r, .upper_address_port_r, .misc_control_r, .loader_settings_r,
  .serial_tx_data_r, .serial_tx_start_r, .port_pin_out_r, .port_pin_oe_r);
`default_nettype wire

// *** verif/ids_cpu_model.sv ***
`timescale 1ns/10ps
`default_nettype none
// ****************************************
// Core-side access driver
// ****************************************
module ids_cpu_model (
  input  wire logic        sys_clk,
  input  wire logic [7:0]  rd_data_r,
  input  wire logic        bit_rd_data_r,
  output var  logic        acc_rd,
  output var  logic        acc_wr,
  output var  logic [1:0]  acc_mode,
  output var  logic [7:0]  acc_addr,
  output var  logic [7:0]  acc_wdata,
  output var  logic        bit_rd,
  output var  logic        bit_wr,
  output var  logic [7:0]  bit_addr,
  output var  logic        bit_wval,
  output var  logic        data_pointer_wr,
  output var  logic [15:0] data_pointer_wdata
);
  // Idle bus from time zero
  initial begin
    {acc_rd, acc_wr, bit_rd, bit_wr, data_pointer_wr} = 5'h00;
    {acc_mode, acc_addr, acc_wdata, bit_addr, bit_wval, data_pointer_wdata} = 43'h0;
  end
  // One access, held through the taking edge, released after it
  task automatic op(input logic [4:0] s, input logic [1:0] m, input logic [7:0] a, d,
                    input logic [15:0] p);
    @(negedge sys_clk);
    {acc_rd, acc_wr, bit_rd, bit_wr, data_pointer_wr} = s;
    {acc_mode, acc_addr, acc_wdata, bit_addr, bit_wval, data_pointer_wdata} = {m, a, d, a, d[0], p};
    @(posedge sys_clk);
    @(negedge sys_clk);
    {acc_rd, acc_wr, bit_rd, bit_wr, data_pointer_wr} = 5'h00;
    // Released address and data flip so stale values never look valid
    {acc_addr, acc_wdata, data_pointer_wdata} = ~{acc_addr, acc_wdata, data_pointer_wdata};
  endtask
  task automatic wr(input logic [1:0] m, input logic [7:0] a, d);
    op(5'h08, m, a, d, 16'h0000);
  endtask
  task automatic rd(input logic [1:0] m, input logic [7:0] a, output logic [7:0] q);
    op(5'h10, m, a, 8'h00, 16'h0000);
    q = rd_data_r;
  endtask
  task automatic bw(input logic [7:0] a, input logic v);
    op(5'h02, 2'h0, a, {7'h00, v}, 16'h0000);
  endtask
  task automatic br(input logic [7:0] a, output logic v);
    op(5'h04, 2'h0, a, 8'h00, 16'h0000);
    v = bit_rd_data_r;
  endtask
  task automatic pw(input logic [15:0] p);
    op(5'h01, 2'h0, 8'h00, 8'h00, p);
  endtask
endmodule // ids_cpu_model
`default_nettype wire

// *** verif/idata_sfr_space_decoder_tb.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "ids_consts.vh"
module idata_sfr_space_decoder_tb;
  localparam logic [1:0] md = `IDS_MODE_DIRECT;
  localparam logic [1:0] mi = `IDS_MODE_INDIRECT;
  localparam logic [1:0] mr = `IDS_MODE_REGISTER;
  logic        sys_clk, rst, b;
  logic [23:0] serial_rx_data;
  logic [31:0] port_pin_in, pin_ext;
  wire logic   acc_rd, acc_wr, bit_rd, bit_wr, bit_wval, data_pointer_wr, bit_rd_data_r;
  wire logic [1:0]  acc_mode;
  wire logic [7:0]  acc_addr, acc_wdata, bit_addr, rd_data_r, stack_pointer_r;
  wire logic [7:0]  upper_address_port_r, misc_control_r, loader_settings_r;
  wire logic [15:0] data_pointer_wdata, data_pointer_zero_r, data_pointer_one_r;
  wire logic [23:0] serial_tx_data_r;
  wire logic [2:0]  serial_tx_start_r;
  wire logic [31:0] port_pin_out_r, port_pin_oe_r;
  int errors, compares;
  logic [7:0] ta [7] = '{`IDS_A_TL0, `IDS_A_TL1, `IDS_A_TH0, `IDS_A_TH1,
                         `IDS_A_TL2, `IDS_A_TH2, `IDS_A_WDT};
  // Pins: driven where enabled, pull-up or outside level elsewhere
  assign port_pin_in = (port_pin_oe_r & port_pin_out_r) | (~port_pin_oe_r & pin_ext);
  ids_space uut (.sys_clk, .rst, .acc_rd, .acc_wr, .acc_mode, .acc_addr, .acc_wdata,
    .bit_rd, .bit_wr, .bit_addr, .bit_wval, .data_pointer_wr, .data_pointer_wdata, .serial_rx_data,
    .port_pin_in, .rd_data_r, .bit_rd_data_r, .stack_pointer_r, .data_pointer_zero_r,
    .data_pointer_one_r, .upper_address_port_r, .misc_control_r, .loader_settings_r,
    .serial_tx_data_r, .serial_tx_start_r, .port_pin_out_r, .port_pin_oe_r);
  ids_cpu_model cpu (.sys_clk, .rd_data_r, .bit_rd_data_r, .acc_rd, .acc_wr, .acc_mode,
    .acc_addr, .acc_wdata, .bit_rd, .bit_wr, .bit_addr, .bit_wval, .data_pointer_wr, .data_pointer_wdata);
  task automatic chk(input logic [31:0] got, exp);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Byte read and compare
  task automatic rc(input logic [1:0] m, input logic [7:0] a, e);
    logic [7:0] v;
    cpu.rd(m, a, v);
    chk(v, e);
  endtask
  task automatic conclude;
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic t_reset;
    rc(md, `IDS_A_SP, 8'h07);
    rc(md, `IDS_A_PSW, 8'h00);
    chk(loader_settings_r, 8'h00);
    chk(port_pin_oe_r, 32'h00000000);
    $display("test reset done");
  endtask
  task automatic t_banks;
    cpu.wr(md, 8'h03, 8'h5A);
    cpu.wr(md, 8'h0B, 8'hA5);
    cpu.wr(md, 8'h1B, 8'h3C);
    cpu.wr(md, `IDS_A_PSW, 8'h08);
    rc(mr, 8'h03, 8'hA5);
    rc(md, `IDS_A_PSW, 8'h08);
    cpu.wr(md, `IDS_A_PSW, 8'h18);
    rc(mr, 8'h03, 8'h3C);
    cpu.wr(md, `IDS_A_PSW, 8'h00);
    rc(mr, 8'h03, 8'h5A);
    rc(mi, 8'h0B, 8'hA5);
    cpu.wr(mi, 8'h7F, 8'h6E);
    rc(md, 8'h7F, 8'h6E);
    $display("test banks done");
  endtask
  task automatic t_split;
    cpu.wr(md, `IDS_A_B, 8'h3C);
    cpu.wr(mi, `IDS_A_B, 8'hC3);
    cpu.wr(mi, `IDS_A_SP, 8'h99);
    rc(md, `IDS_A_B, 8'h3C);
    rc(mi, `IDS_A_B, 8'hC3);
    rc(md, `IDS_A_SP, 8'h07);
    rc(mi, `IDS_A_SP, 8'h99);
    cpu.wr(md, `IDS_A_SP, 8'hFF);
    rc(md, `IDS_A_SP, 8'hFF);
    $display("test split done");
  endtask
  task automatic t_parity;
    cpu.wr(md, `IDS_A_ACC, 8'h07);
    rc(md, `IDS_A_PSW, 8'h01);
    cpu.wr(md, `IDS_A_PSW, 8'hFE);
    rc(md, `IDS_A_PSW, 8'hFF);
    cpu.wr(md, `IDS_A_ACC, 8'h03);
    rc(md, `IDS_A_PSW, 8'hFE);
    cpu.wr(md, `IDS_A_PSW, 8'h00);
    rc(md, `IDS_A_ACC, 8'h03);
    $display("test parity done");
  endtask
  task automatic t_bits;
    cpu.wr(md, 8'h20, 8'h00);
    cpu.wr(md, 8'h2F, 8'h00);
    cpu.bw(8'h07, 1'b1);
    cpu.bw(8'h7F, 1'b1);
    rc(md, 8'h20, 8'h80);
    rc(md, 8'h2F, 8'h80);
    cpu.br(8'h7F, b);
    chk(b, 1'b1);
    cpu.bw(8'hF1, 1'b1);
    rc(md, `IDS_A_B, 8'h3E);
    cpu.bw(8'hE7, 1'b1);
    rc(md, `IDS_A_ACC, 8'h83);
    $display("test bits done");
  endtask
  task automatic t_data_pointer;
    cpu.wr(md, `IDS_A_DPL, 8'h34);
    cpu.wr(md, `IDS_A_DPH, 8'h12);
    chk(data_pointer_zero_r, 16'h1234);
    cpu.wr(md, `IDS_A_MISC_CONTROL, 8'hFF);
    chk(misc_control_r, 8'h39);
    cpu.pw(16'hAB00);
    cpu.wr(md, `IDS_A_DPL, 8'hCD);
    chk(data_pointer_one_r, 16'hABCD);
    chk(data_pointer_zero_r, 16'h1234);
    rc(md, `IDS_A_DPH, 8'hAB);
    cpu.wr(md, `IDS_A_MISC_CONTROL, 8'h00);
    rc(md, `IDS_A_DPH, 8'h12);
    cpu.pw(16'h5678);
    chk(data_pointer_zero_r, 16'h5678);
    chk(data_pointer_one_r, 16'hABCD);
    $display("test pointers done");
  endtask
  task automatic t_serial;
    rc(md, `IDS_A_SBUF0, 8'h11);
    rc(md, `IDS_A_SBUF2, 8'h33);
    cpu.wr(md, `IDS_A_SBUF1, 8'hC7);
    chk(serial_tx_start_r, 3'h2);
    chk(serial_tx_data_r[15:8], 8'hC7);
    @(negedge sys_clk);
    chk(serial_tx_start_r, 3'h0);
    rc(md, `IDS_A_SBUF1, 8'h22);
    $display("test serial done");
  endtask
  task automatic t_ports;
    cpu.wr(md, `IDS_A_P3, 8'hFE);
    @(negedge sys_clk);
    chk(port_pin_out_r[15:8], 8'hFE);
    chk(port_pin_oe_r[15:8], 8'h01);
    cpu.wr(md, `IDS_A_P3, 8'hFF);
    @(negedge sys_clk);
    chk(port_pin_oe_r[15:8], 8'h01);
    @(negedge sys_clk);
    chk(port_pin_oe_r[15:8], 8'h00);
    cpu.wr(md, `IDS_A_P3M, 8'h80);
    pin_ext[15:8] = 8'h5A;
    repeat (3) @(negedge sys_clk);
    chk(port_pin_oe_r[15:8], 8'h80);
    rc(md, `IDS_A_P3, 8'hDA);
    cpu.wr(md, `IDS_A_P2, 8'h9A);
    cpu.wr(mi, `IDS_A_P2, 8'h11);
    chk(upper_address_port_r, 8'h9A);
    $display("test ports done");
  endtask
  task automatic t_misc;
    cpu.wr(md, `IDS_A_LOADER_SETTINGS, 8'hFF);
    rc(md, `IDS_A_LOADER_SETTINGS, 8'h07);
    for (int i = 0; i < 7; i++) cpu.wr(md, ta[i], ta[i] ^ 8'h5A);
    for (int i = 0; i < 7; i++) rc(md, ta[i], ta[i] ^ 8'h5A);
    $display("test misc done");
  endtask
  // Clock, 100 ns period
  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end
  // Watchdog cuts a hang short
  initial begin
    repeat (3000) @(posedge sys_clk);
    errors++;
    conclude();
  end
  // Main sequence
  initial begin
    errors = 0;
    compares = 0;
    rst = 1'b1;
    pin_ext = 32'hFFFFFFFF;
    serial_rx_data = 24'h332211;
    repeat (10) @(negedge sys_clk);
    rst = 1'b0;
    t_reset();
    t_banks();
    t_split();
    t_parity();
    t_bits();
    t_data_pointer();
    t_serial();
    t_ports();
    t_misc();
    conclude();
  end
endmodule // idata_sfr_space_decoder_tb
`default_nettype wire
